/* tio_pkg.sv */
package tio_pkg;
  localparam int NPORT = 6;
  localparam int NCLK = 6;
  localparam int NPIN = 32;
  localparam int XW = 32;
  localparam int CW = 16;
  localparam int AW = 12;
  localparam int CTRL_W = 16;
  localparam int CLK_W = 16;
  localparam int PORT_W [NPORT] = '{1, 1, 4, 8, 16, 32};
  localparam int PORT_BASE [NPORT] = '{0, 1, 0, 0, 0, 0};
  localparam logic [NPIN-1:0] LINK_PINS = 32'h0000_000F;
  localparam int CLK_HZ = 125_000_000;
  localparam int REF_HZ = 100_000_000;
  localparam logic [7:0] ACC_MOD = 8'(CLK_HZ / 1_000_000);
  localparam logic [7:0] ACC_STEP = 8'(REF_HZ / 1_000_000);
  localparam logic [AW-1:0] PORT_END = 12'h0C0;
  localparam logic [AW-1:0] CLKB_BASE = 12'h200;
  localparam logic [AW-1:0] CLKB_END = 12'h218;
  localparam logic [AW-1:0] GLOBAL_OFS = 12'h300;
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_COND = 3'h1;
  localparam logic [2:0] R_TIME = 3'h2;
  localparam logic [2:0] R_DATA = 3'h3;
  localparam logic [2:0] R_COUNT = 3'h4;
  localparam logic [2:0] R_TSTAMP = 3'h5;
  localparam logic [2:0] R_STATUS = 3'h6;
  localparam int C_EN = 0;
  localparam int C_OUT = 1;
  localparam int C_OD = 2;
  localparam int C_SIN = 3;
  localparam int C_SOUT = 4;
  localparam int C_COND = 5;
  localparam int C_TIMED = 6;
  localparam int C_CLK = 8;
  localparam int K_EXT = 0;
  localparam int K_PSEL = 1;
  localparam int K_DIV = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [CLK_W-1:0] CLK_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {TIO_WS_IDLE, TIO_WS_RESP} tio_wst_t;
endpackage

/* tio_port_if.sv */
interface tio_port_if #(parameter int W = 1);
  logic tick;
  logic en;
  logic dir_out;
  logic sin_en;
  logic sout_en;
  logic cond_en;
  logic timed;
  logic strobe_in;
  logic [W-1:0] pin_in;
  logic [W-1:0] cond_v;
  logic [15:0] time_v;
  logic wr;
  logic rd_ack;
  logic [31:0] wdata;
  logic [W-1:0] pout;
  logic sout;
  logic [15:0] cnt;
  logic [15:0] ts;
  logic [31:0] rdata;
  logic full;
  modport ctl (output tick, en, dir_out, sin_en, sout_en, cond_en, timed, strobe_in, pin_in,
    cond_v, time_v, wr, rd_ack, wdata, input pout, sout, cnt, ts, rdata, full);
  modport port (input tick, en, dir_out, sin_en, sout_en, cond_en, timed, strobe_in, pin_in,
    cond_v, time_v, wr, rd_ack, wdata, output pout, sout, cnt, ts, rdata, full);
endinterface

/* tio_clkblk.sv */
module tio_clkblk
  import tio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ref_tick_i,
  input wire logic ext_i,
  input wire logic use_ext_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  typedef struct packed {
    logic prev;
    logic [7:0] dcnt;
  } tio_clkblk_st_t;
  tio_clkblk_st_t s, n;
  logic ev;

  always_comb
  begin
    n = s;
    n.prev = ext_i;
    ev = use_ext_i ? (ext_i && !s.prev) : ref_tick_i;
    tick_o = ev && (s.dcnt == div_i);
    if (ev)
      n.dcnt = tick_o ? 8'h00 : s.dcnt + 8'h01;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= n;
  end
endmodule

/* tio_port.sv */
module tio_port
  import tio_pkg::*;
#(parameter int W = 1)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  tio_port_if.port pif
);
  localparam logic [5:0] SH_LAST = 6'(XW / W - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [CW-1:0] ts;
    logic [XW-1:0] xfer;
    logic [XW-1:0] sreg;
    logic [5:0] nsh;
    logic full;
    logic busy;
    logic [W-1:0] pout;
    logic sout;
  } tio_port_st_t;
  tio_port_st_t s, n;
  logic time_ok;
  logic ready;
  logic cond_ok;

  always_comb
  begin
    n = s;
    time_ok = !pif.timed || (s.cnt == pif.time_v);
    ready = !pif.sin_en || pif.strobe_in;
    cond_ok = !pif.cond_en || (pif.pin_in == pif.cond_v);
    // read clears first so a capture in the same cycle wins
    if (pif.rd_ack && !pif.dir_out)
      n.full = 1'b0;
    if (pif.tick && pif.en)
    begin
      n.cnt = s.cnt + 16'h0001;
      if (pif.dir_out)
      begin
        n.sout = 1'b0;
        if (ready && s.busy)
        begin
          n.pout = s.sreg[W-1:0];
          n.sreg = s.sreg >> W;
          n.nsh = s.nsh - 6'h01;
          n.busy = (s.nsh != 6'h01);
          n.sout = pif.sout_en;
        end
        else if (ready && s.full && time_ok)
        begin
          n.pout = s.xfer[W-1:0];
          n.sreg = s.xfer >> W;
          n.nsh = SH_LAST;
          n.busy = (SH_LAST != 6'h00);
          n.full = 1'b0;
          n.ts = s.cnt;
          n.sout = pif.sout_en;
        end
      end
      else if (ready && (s.busy || (cond_ok && time_ok)))
      begin
        // the whole declared width is shifted in, owned pins or not
        n.sreg = XW'({pif.pin_in, s.sreg} >> W);
        if (s.nsh == SH_LAST)
        begin
          n.xfer = n.sreg;
          n.full = 1'b1;
          n.ts = s.cnt;
          n.nsh = 6'h00;
          n.busy = 1'b0;
        end
        else
        begin
          n.nsh = s.nsh + 6'h01;
          n.busy = 1'b1;
        end
      end
    end
    if (pif.wr && pif.dir_out)
    begin
      n.xfer = pif.wdata;
      n.full = 1'b1;
    end
  end

  assign pif.pout = s.pout;
  assign pif.sout = s.sout;
  assign pif.cnt = s.cnt;
  assign pif.ts = s.ts;
  assign pif.rdata = s.xfer;
  assign pif.full = s.full;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= n;
  end
endmodule

/* tio_top.sv */
module tio_top
  import tio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_o,
  output logic pull_dn_o,
  input wire logic [NPORT-1:0] strobe_in_i,
  output logic [NPORT-1:0] strobe_out_o
);
  typedef struct packed {
    logic [NPORT-1:0][CTRL_W-1:0] ctrl;
    logic [NPORT-1:0][XW-1:0] cond;
    logic [NPORT-1:0][CW-1:0] tval;
    logic [NCLK-1:0][CLK_W-1:0] ccfg;
    logic link_en;
    logic [7:0] acc;
    tio_wst_t wst;
    logic aw_got;
    logic w_got;
    logic [AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tio_top_st_t;
  tio_top_st_t s, n;

  logic ref_tick;
  logic [NCLK-1:0] cb_tick;
  logic [NPORT-1:0] p_tick;
  logic [NPORT-1:0] p_wr;
  logic [NPORT-1:0] p_rdack;
  logic [NPORT-1:0][CW-1:0] p_cnt;
  logic [NPORT-1:0][CW-1:0] p_ts;
  logic [NPORT-1:0][XW-1:0] p_rdata;
  logic [NPORT-1:0][NPIN-1:0] p_pout;
  logic [NPORT-1:0] p_full;
  logic [NPORT-1:0] p_sout;
  logic aw_ok;
  logic w_ok;
  logic [AW-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [2:0] wp;
  logic [2:0] rp;
  logic [2:0] wk;
  logic [2:0] rk;

  // the last word of a port's window is unmapped and answers with an error
  function automatic logic is_port(input logic [AW-1:0] a);
    is_port = (a < PORT_END) && (a[1:0] == 2'h0) && (a[4:2] <= R_STATUS);
  endfunction

  function automatic logic is_clkb(input logic [AW-1:0] a);
    is_clkb = (a >= CLKB_BASE) && (a < CLKB_END) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    merge = r;
  endfunction

  // fractional divider: 125 MHz carries ACC_STEP of ACC_MOD, averaging the reference rate
  assign ref_tick = ({1'b0, s.acc} + {1'b0, ACC_STEP}) >= {1'b0, ACC_MOD};

  // block zero is the fixed reference; its config is never written
  genvar k;
  generate
    for (k = 0; k < NCLK; k++)
    begin : gen_cb
      tio_clkblk u_cb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ref_tick_i(ref_tick),
        .ext_i(pin_i[PORT_BASE[s.ccfg[k][K_PSEL] ? 1 : 0]]),
        .use_ext_i(s.ccfg[k][K_EXT]),
        .div_i(s.ccfg[k][K_DIV +: 8]),
        .tick_o(cb_tick[k])
      );
    end
  endgenerate

  // ports read pins over their whole width even where a narrower port owns some of them
  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : gen_port
      localparam int W = PORT_W[g];
      localparam int B = PORT_BASE[g];
      tio_port_if #(.W(W)) pif ();
      logic [2:0] sel;
      assign sel = s.ctrl[g][C_CLK +: 3];
      assign p_tick[g] = (sel < 3'(NCLK)) ? cb_tick[sel] : 1'b0;
      assign pif.tick = p_tick[g];
      assign pif.en = s.ctrl[g][C_EN];
      assign pif.dir_out = s.ctrl[g][C_OUT];
      assign pif.sin_en = s.ctrl[g][C_SIN];
      assign pif.sout_en = s.ctrl[g][C_SOUT];
      assign pif.cond_en = s.ctrl[g][C_COND];
      assign pif.timed = s.ctrl[g][C_TIMED];
      assign pif.strobe_in = strobe_in_i[g];
      assign pif.pin_in = pin_i[B +: W];
      assign pif.cond_v = s.cond[g][W-1:0];
      assign pif.time_v = s.tval[g];
      assign pif.wr = p_wr[g];
      assign pif.rd_ack = p_rdack[g];
      assign pif.wdata = wd;
      assign p_cnt[g] = pif.cnt;
      assign p_ts[g] = pif.ts;
      assign p_rdata[g] = pif.rdata;
      assign p_full[g] = pif.full;
      assign p_sout[g] = pif.sout;
      assign p_pout[g] = NPIN'(pif.pout) << B;
      tio_port #(.W(W)) u_port (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pif(pif)
      );
    end
  endgenerate

  assign strobe_out_o = p_sout;
  // pull-downs follow the reset pin itself, so they act before the clock runs
  assign pull_dn_o = !rst_n_i;

  // pin ownership: ports are ordered narrow to wide, first enabled one wins
  always_comb
  begin
    logic hit;
    logic bitv;
    hit = 1'b0;
    bitv = 1'b0;
    pin_o = '0;
    pin_oe_o = '0;
    for (int i = 0; i < NPIN; i++)
    begin
      hit = 1'b0;
      for (int p = 0; p < NPORT; p++)
      begin
        if (!hit && s.ctrl[p][C_EN] && (i >= PORT_BASE[p]) && (i < PORT_BASE[p] + PORT_W[p]))
        begin
          hit = 1'b1;
          bitv = p_pout[p][i];
          if (s.ctrl[p][C_OUT])
          begin
            pin_o[i] = s.ctrl[p][C_OD] ? 1'b0 : bitv;
            pin_oe_o[i] = s.ctrl[p][C_OD] ? !bitv : 1'b1;
          end
        end
      end
      // the link overrides every port on its pins, whatever their direction
      if (s.link_en && LINK_PINS[i])
      begin
        pin_o[i] = 1'b0;
        pin_oe_o[i] = 1'b0;
      end
    end
  end

  // one write at a time: both readies stay low from pairing until the response is taken
  assign s_axi_awready = !s.aw_got && (s.wst == TIO_WS_IDLE);
  assign s_axi_wready = !s.w_got && (s.wst == TIO_WS_IDLE);
  assign s_axi_bvalid = (s.wst == TIO_WS_RESP);
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // a half taken earlier is held in state and paired with the other half here
  assign aw_ok = s.aw_got || (s_axi_awvalid && s_axi_awready);
  assign w_ok = s.w_got || (s_axi_wvalid && s_axi_wready);
  assign wa = s.aw_got ? s.awaddr : s_axi_awaddr;
  assign wd = s.w_got ? s.wdata : s_axi_wdata;
  assign ws = s.w_got ? s.wstrb : s_axi_wstrb;
  assign wp = wa[7:5];
  assign wk = 3'(wa[4:2] + 3'h0);
  assign rp = s_axi_araddr[7:5];
  assign rk = s_axi_araddr[4:2];

  always_comb
  begin
    n = s;
    p_wr = '0;
    p_rdack = '0;
    // the reference phase runs whether or not a port uses block zero
    n.acc = ref_tick ? s.acc + ACC_STEP - ACC_MOD : s.acc + ACC_STEP;

    // write channel: address and data in either order, answer next cycle
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    case (s.wst)
      TIO_WS_IDLE:
      begin
        if (aw_ok && w_ok)
        begin
          n.aw_got = 1'b0;
          n.w_got = 1'b0;
          n.wst = TIO_WS_RESP;
          n.bresp = RESP_OKAY;
          if (is_port(wa))
          begin
            if (wk == R_CTRL)
              n.ctrl[wp] = CTRL_W'(merge(32'(s.ctrl[wp]), wd, ws));
            else if (wk == R_COND)
              n.cond[wp] = merge(s.cond[wp], wd, ws);
            else if (wk == R_TIME)
              n.tval[wp] = CW'(merge(32'(s.tval[wp]), wd, ws));
            else if (wk == R_DATA)
              p_wr[wp] = 1'b1;
          end
          else if (is_clkb(wa))
          begin
            if (wa[4:2] != 3'h0)
              n.ccfg[wa[4:2]] = CLK_W'(merge(32'(s.ccfg[wa[4:2]]), wd, ws));
          end
          else if (wa == GLOBAL_OFS)
          begin
            if (ws[0])
              n.link_en = wd[0];
          end
          else
            n.bresp = RESP_SLVERR;
        end
      end
      TIO_WS_RESP:
      begin
        if (s_axi_bready)
          n.wst = TIO_WS_IDLE;
      end
      default:
        n.wst = TIO_WS_IDLE;
    endcase

    // read channel: data registered one cycle after the address is taken
    if (s.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (is_port(s_axi_araddr))
      begin
        if (rk == R_CTRL)
          n.rdata = 32'(s.ctrl[rp]);
        else if (rk == R_COND)
          n.rdata = s.cond[rp];
        else if (rk == R_TIME)
          n.rdata = 32'(s.tval[rp]);
        else if (rk == R_DATA)
        begin
          n.rdata = p_rdata[rp];
          p_rdack[rp] = 1'b1;
        end
        else if (rk == R_COUNT)
          n.rdata = 32'(p_cnt[rp]);
        else if (rk == R_TSTAMP)
          n.rdata = 32'(p_ts[rp]);
        else
          n.rdata = 32'(p_full[rp]);
      end
      else if (is_clkb(s_axi_araddr))
        n.rdata = 32'(s.ccfg[s_axi_araddr[4:2]]);
      else if (s_axi_araddr == GLOBAL_OFS)
        n.rdata = 32'(s.link_en);
      else
        n.rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.ctrl <= {NPORT{CTRL_RST}};
      s.ccfg <= {NCLK{CLK_RST}};
      s.wst <= TIO_WS_IDLE;
    end
    else
      s <= n;
  end
endmodule

/* tio_chk_asserts.sv */
module tio_chk
  import tio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPIN-1:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [AW-1:0] wa_r;
  logic wd_r;
  logic ws_r;
  logic aw_h;
  logic w_h;
  logic link_r;
  logic aw_now;
  logic w_now;
  logic pair;
  logic [AW-1:0] wa_c;
  assign aw_now = s_axi_awvalid && s_axi_awready;
  assign w_now = s_axi_wvalid && s_axi_wready;
  assign pair = (aw_now || aw_h) && (w_now || w_h);
  assign wa_c = aw_now ? s_axi_awaddr : wa_r;
  // link state mirrored at the edge where a write pairs up, which is when the block applies it
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      wa_r <= '0;
      wd_r <= 1'b0;
      ws_r <= 1'b0;
      aw_h <= 1'b0;
      w_h <= 1'b0;
      link_r <= 1'b0;
    end
    else
    begin
      if (aw_now)
        wa_r <= s_axi_awaddr;
      if (w_now)
      begin
        wd_r <= s_axi_wdata[0];
        ws_r <= s_axi_wstrb[0];
      end
      aw_h <= (aw_h || aw_now) && !pair;
      w_h <= (w_h || w_now) && !pair;
      if (pair && wa_c == GLOBAL_OFS && (w_now ? s_axi_wstrb[0] : ws_r))
        link_r <= w_now ? s_axi_wdata[0] : wd_r;
    end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rd_close_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  wr_close_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  link_free_a: assert property (link_r |-> (pin_oe_o & LINK_PINS) == '0)
    else $error("port drives link pins");
endmodule
bind tio_top tio_chk chk (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe_o);

/* tio_ext.sv */
module tio_ext
  import tio_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NPIN-1:0] pin_o_i,
  input wire logic [NPIN-1:0] oe_i,
  input wire logic pull_i,
  input wire logic [NPIN-1:0] drv_en_i,
  input wire logic [NPIN-1:0] drv_val_i,
  input wire logic app_en_i,
  output logic [NPIN-1:0] pin_i_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NPIN-1:0] float_r = '0;
  // a floating pin toggles so a stale level never passes for data
  logic [1:0] half_r = '0;
  logic app_clk_r = 1'b0;
  always @(posedge clk_i)
    float_r <= ~float_r;
  // application clock on pin 1, six system cycles a period, held low while disabled
  always @(posedge clk_i)
    if (!app_en_i)
    begin
      half_r <= 2'h0;
      app_clk_r <= 1'b0;
    end
    else if (half_r == 2'h2)
    begin
      half_r <= 2'h0;
      app_clk_r <= ~app_clk_r;
    end
    else
      half_r <= half_r + 2'h1;
  always_comb
    for (int i = 0; i < NPIN; i++)
      pin_i_o[i] = oe_i[i] ? pin_o_i[i] : (app_en_i && i == 1) ? app_clk_r :
        drv_en_i[i] ? drv_val_i[i] : pull_i ? 1'b0 : float_r[i];
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [AW-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd_v, pin_in, po, poe, dev = '0, dvv = '0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0, app_en = 1'b0;
  logic awr, wr_r, bv, arr, rv, pd;
  logic [1:0] br, rr;
  logic [NPORT-1:0] sti = '0, sto;
  int bad_count = 0;
  int samples_checked = 0;
  always #4 clk_i = ~clk_i;
  tio_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_v),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .pin_i(pin_in), .pin_o(po),
    .pin_oe_o(poe), .pull_dn_o(pd), .strobe_in_i(sti), .strobe_out_o(sto));
  tio_ext ext (.clk_i(clk_i), .pin_o_i(po), .oe_i(poe), .pull_i(pd), .drv_en_i(dev),
    .drv_val_i(dvv), .app_en_i(app_en), .pin_i_o(pin_in));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic hang(string n);
    bad_count++;
    $display("MISMATCH %s exp done got timeout", n);
    tally_and_finish();
  endtask
  function automatic logic [AW-1:0] ra(int p, logic [2:0] r);
    return AW'(p * 32 + r * 4);
  endfunction
  task automatic wr(logic [AW-1:0] a, logic [31:0] d, logic [1:0] e = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wr_r)
        wv <= 1'b0;
      if (++n > 50)
        hang("write");
    end
    while (!(bv && brd));
    brd <= 1'b0;
    chk("bresp", e, br);
  endtask
  task automatic rd(logic [AW-1:0] a, output logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arv && arr)
        arv <= 1'b0;
      if (++n > 50)
        hang("read");
    end
    while (!(rv && rrd));
    rrd <= 1'b0;
    d = rd_v;
    chk("rresp", e, rr);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    @(posedge clk_i);
    chk("pull_after", 0, pd);
    rd(ra(3, R_CTRL), d);
    chk("ctrl_rst", CTRL_RST, d);
    rd(12'h100, d, RESP_SLVERR);
    chk("unmapped", 0, d);
    wr(CLKB_BASE, 32'h0000_0103);
    rd(CLKB_BASE, d);
    chk("ref_block", CLK_RST, d);
    wr(ra(2, R_COND), 32'h0000_000A);
    rd(ra(2, R_COND), d);
    chk("cond", 32'h0000_000A, d);
  endtask
  task automatic t_out();
    logic [31:0] ts, c1, c2;
    int n;
    wr(ra(3, R_CTRL), 32'h0000_001B);
    wr(ra(3, R_DATA), 32'h4433_2211);
    repeat (20) @(posedge clk_i);
    chk("held_strobe", 0, sto[3]);
    sti[3] <= 1'b1;
    n = 0;
    while (sto[3] !== 1'b1)
    begin
      @(posedge clk_i);
      if (++n > 100)
        hang("strobe");
    end
    chk("chunk0", 8'h11, po[7:0]);
    chk("oe_dir", 32'h0000_00FF, poe);
    while (po[7:0] === 8'h11)
    begin
      @(posedge clk_i);
      if (++n > 100)
        hang("shift");
    end
    chk("chunk1", 8'h22, po[7:0]);
    rd(ra(3, R_TSTAMP), ts);
    rd(ra(3, R_COUNT), c1);
    rd(ra(3, R_COUNT), c2);
    chk("count_step", 1, 16'(c2 - c1) inside {[1:8]});
    chk("stamp_past", 1, 16'(c1 - ts) inside {[1:40]});
    wr(GLOBAL_OFS, 32'h0000_0001);
    @(posedge clk_i);
    chk("link_pins", 8'hF0, poe[7:0]);
    wr(GLOBAL_OFS, 32'h0000_0000);
  endtask
  task automatic t_od();
    int n;
    // port 3 still drives pin 0 high-enabled, so a float proves the narrow port owns it
    wr(ra(0, R_CTRL), 32'h0000_0007);
    wr(ra(0, R_DATA), 32'h0000_0002);
    n = 0;
    while (poe[0] !== 1'b0)
    begin
      @(posedge clk_i);
      if (++n > 100)
        hang("od_float");
    end
    chk("wide_keeps", 8'hFE, poe[7:0]);
    while (poe[0] !== 1'b1)
    begin
      @(posedge clk_i);
      if (++n > 100)
        hang("od_low");
    end
    chk("od_zero", 0, po[0]);
    wr(ra(0, R_CTRL), 32'h0000_0000);
    wr(ra(3, R_CTRL), 32'h0000_0000);
  endtask
  task automatic t_clk();
    logic [31:0] c1, c2, ts;
    int n;
    app_en <= 1'b1;
    repeat (8) @(posedge clk_i);
    wr(CLKB_BASE + 12'h004, 32'h0000_0103);
    wr(ra(4, R_CTRL), 32'h0000_0101);
    rd(ra(4, R_COUNT), c1);
    repeat (48) @(posedge clk_i);
    rd(ra(4, R_COUNT), c2);
    chk("ext_div_rate", 1, 16'(c2 - c1) inside {[4:5]});
    wr(ra(4, R_CTRL), 32'h0000_0000);
    wr(CLKB_BASE + 12'h004, 32'h0000_0000);
    app_en <= 1'b0;
    wr(ra(1, R_CTRL), 32'h0000_0043);
    rd(ra(1, R_COUNT), c1);
    wr(ra(1, R_TIME), c1 + 32'h0000_001E);
    wr(ra(1, R_DATA), 32'h0000_0001);
    n = 0;
    while (po[1] !== 1'b1)
    begin
      @(posedge clk_i);
      if (++n > 200)
        hang("timed");
    end
    rd(ra(1, R_TSTAMP), ts);
    chk("timed_stamp", c1 + 32'h0000_001E, ts);
    wr(ra(1, R_CTRL), 32'h0000_0000);
  endtask
  task automatic t_in();
    logic [31:0] d;
    int n;
    dev <= 32'h0000_000F;
    dvv <= 32'h0000_000A;
    wr(ra(2, R_CTRL), 32'h0000_0021);
    n = 0;
    d = '0;
    while (d[0] !== 1'b1)
    begin
      rd(ra(2, R_STATUS), d);
      if (++n > 30)
        hang("capture");
    end
    // stop the port so the next capture cannot refill the word before the checks
    wr(ra(2, R_CTRL), 32'h0000_0020);
    rd(ra(2, R_DATA), d);
    chk("in_word", 32'hAAAA_AAAA, d);
    rd(ra(2, R_STATUS), d);
    chk("full_clear", 0, d[0]);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    chk("pull_in_reset", 1, pd);
    chk("oe_in_reset", 0, poe);
    rst_n_i <= 1'b1;
    t_regs();
    t_out();
    t_od();
    t_clk();
    t_in();
    tally_and_finish();
  end
endmodule
